// [shared/flash_prot_map.vh]
`ifndef FLASH_PROT_MAP_VH
`define FLASH_PROT_MAP_VH
// ------------------------------------------------------------------
// Register indices (byte address = 4 * index)
// ------------------------------------------------------------------
`define CFG_INDEX        8'h03
`define PROT_INDEX       8'h04
`define STAT_INDEX       8'h05
`define CFG_ADDR         8'h0c
`define PROT_ADDR        8'h10
`define STAT_ADDR        8'h14
// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CFG_BEIE_BIT     7
`define CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT     6
`define CFG_KEY_BIT      5
`define CFG_MASK         8'he0
`define PROT_POL_BIT     7
`define PROT_HDIS_BIT    5
`define PROT_LDIS_BIT    2
`define STAT_VIOL_BIT    5
`define BACKDOOR_KEY_ENABLE_ENABLED    2'b10
`define CFG_RESET        8'h00
`define PROT_RESET       8'hff
`define PROT_NVM_ADDR    16'hff0d
// ------------------------------------------------------------------
// Range bounds
// ------------------------------------------------------------------
`define HIGH_END         16'hffff
`define LOW_BASE         16'h4000
`define HIGH_BASE0       16'hf800
`define HIGH_BASE1       16'hf000
`define HIGH_BASE2       16'he000
`define HIGH_BASE3       16'hc000
`define LOW_END0         16'h43ff
`define LOW_END1         16'h47ff
`define LOW_END2         16'h4fff
`define LOW_END3         16'h5fff
`endif

// [verilog/protect_scenario.v]
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.vh"
// Checks a protection write against the add-only transition table.
module protect_scenario (
  // Current and proposed register values
  input  wire [7:0] protCur,
  input  wire [7:0] protNew,
  // Verdict
  output reg        allowed
);
  // Scenario code: {not polarity, not high disable, not low disable}
  function [2:0] scen;
    input [7:0] p;
    begin
      scen = {~p[`PROT_POL_BIT], ~p[`PROT_HDIS_BIT], ~p[`PROT_LDIS_BIT]};
    end
  endfunction

  wire [2:0] fromS = scen(protCur);
  wire [2:0] toS   = scen(protNew);
  reg  [7:0] row;

  always @* begin
    case (fromS)
      3'd0:    row = 8'h0f;
      3'd1:    row = 8'h0a;
      3'd2:    row = 8'h0c;
      3'd3:    row = 8'h08;
      3'd4:    row = 8'h18;
      3'd5:    row = 8'h3c;
      3'd6:    row = 8'h5a;
      3'd7:    row = 8'hff;
      default: row = 8'h00;
    endcase
    allowed = row[toS];
  end
endmodule // protect_scenario
`default_nettype wire

// [verilog/flash_protection_config.v]
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.vh"
//
// Contract
// - Config: only bits 7,6,5 read/write; others read zero, ignore writes.
// - Key-access gate writable only when backdoor key enable is enabled.
// - Backdoor key enable counts as enabled only for pattern 10.
// - Buffer-empty irq requested while enable and buffer-empty flag set.
// - Command-complete irq requested while enable and complete flag set.
// - Gate clear: array write starts command; set: key write, reads invalid.
// - Protection register readable in normal and special modes.
// - Polarity bit may only be written from one to zero; the scenario check also refuses every one-to-zero write.
// - Low size writable only while low disable bit set.
// - High size writable only while high disable bit set.
// - Protection register loaded from flash byte 0xFF0D at reset.
// - Program/erase into protected area refused, violation flag set.
// - Mass erase only with polarity and both disables set.
// - Polarity one protects ranges; zero makes ranges the open window.
// - High disable zero enables high window; one removes it.
// - Low disable zero enables low window; one removes it.
// - High size selects 2K/4K/8K/16K ranges ending 0xFFFF.
// - Low size selects 1K/2K/4K/8K ranges from 0x4000.
// - Writes removing protection are ignored entirely; a locked size or polarity field is kept, the rest still lands.
module flash_protection_config (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Reset-time load of the protection byte
  input  wire        nvmLoadValid,
  input  wire [7:0]  nvmLoadData,
  output wire [15:0] nvmLoadAddr,
  // Security and status inputs
  input  wire [1:0]  backdoorKeyEnable,
  input  wire        bufferEmptyFlag,
  input  wire        commandCompleteFlag,
  // Flash array access request
  input  wire        arrayReq,
  input  wire        arrayWrite,
  input  wire        arrayMassErase,
  input  wire [15:0] arrayAddr,
  input  wire [15:0] arrayRdRaw,
  // Outputs
  output wire        bufferEmptyIrq,
  output wire        commandCompleteIrq,
  output reg         cmdWriteStart,
  output reg         keyWrite,
  output reg         arrayRefused,
  output reg  [15:0] arrayRdData,
  output wire        protectionViolationFlag
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0] cfg_q;
  reg  [7:0] prot_q;
  reg        loaded_q;
  reg        viol_q;
  reg        wrPend_q;
  reg  [7:0] wrAddr_q;
  wire       protOk;
  reg  [7:0] protNew;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign nvmLoadAddr = `PROT_NVM_ADDR;
  assign protectionViolationFlag = viol_q;

  wire keyEnabled = (backdoorKeyEnable == `BACKDOOR_KEY_ENABLE_ENABLED);
  wire addrPhase  = hsel & hready & htrans[1];

  // ----------------------------------------------------------------
  // Write merge for protection: size fields and polarity guarded
  // ----------------------------------------------------------------
  always @* begin
    protNew = hwdata[7:0];
    if (!prot_q[`PROT_POL_BIT])
      protNew[`PROT_POL_BIT] = 1'b0;
    if (!prot_q[`PROT_HDIS_BIT])
      protNew[4:3] = prot_q[4:3];
    if (!prot_q[`PROT_LDIS_BIT])
      protNew[1:0] = prot_q[1:0];
  end

  protect_scenario u_scen (
    .protCur (prot_q),
    .protNew (protNew),
    .allowed (protOk)
  );

  // ----------------------------------------------------------------
  // Range decode
  // ----------------------------------------------------------------
  function [15:0] highBase;
    input [1:0] s;
    begin
      case (s)
        2'b00:   highBase = `HIGH_BASE0;
        2'b01:   highBase = `HIGH_BASE1;
        2'b10:   highBase = `HIGH_BASE2;
        default: highBase = `HIGH_BASE3;
      endcase
    end
  endfunction

  function [15:0] lowEnd;
    input [1:0] s;
    begin
      case (s)
        2'b00:   lowEnd = `LOW_END0;
        2'b01:   lowEnd = `LOW_END1;
        2'b10:   lowEnd = `LOW_END2;
        default: lowEnd = `LOW_END3;
      endcase
    end
  endfunction

  wire inHigh = ~prot_q[`PROT_HDIS_BIT] &
                (arrayAddr >= highBase(prot_q[4:3]));
  wire inLow  = ~prot_q[`PROT_LDIS_BIT] & (arrayAddr >= `LOW_BASE) &
                (arrayAddr <= lowEnd(prot_q[1:0]));
  // Polarity one: windows protected; zero: windows are the only openings
  wire isProt = prot_q[`PROT_POL_BIT] ? (inHigh | inLow)
                                      : ~(inHigh | inLow);
  wire fullyOpen = prot_q[`PROT_POL_BIT] & prot_q[`PROT_HDIS_BIT] &
                   prot_q[`PROT_LDIS_BIT];
  wire refuse = arrayMassErase ? ~fullyOpen : isProt;

  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      cfg_q        <= `CFG_RESET;
      prot_q       <= `PROT_RESET;
      loaded_q     <= 1'b0;
      viol_q       <= 1'b0;
      wrPend_q     <= 1'b0;
      wrAddr_q     <= 8'h00;
      cmdWriteStart <= 1'b0;
      keyWrite     <= 1'b0;
      arrayRefused <= 1'b0;
      arrayRdData  <= 16'h0000;
      hrdata       <= 32'h00000000;
    end else begin
      wrPend_q <= addrPhase & hwrite;
      wrAddr_q <= haddr;
      // Reset-sequence load happens once and takes priority over a bus write in the same cycle
      if (!loaded_q && nvmLoadValid) begin
        prot_q   <= nvmLoadData;
        loaded_q <= 1'b1;
      end else if (wrPend_q && wrAddr_q == `PROT_ADDR && protOk) begin
        prot_q <= protNew;
      end
      if (wrPend_q && wrAddr_q == `CFG_ADDR) begin
        cfg_q[`CFG_BEIE_BIT] <= hwdata[`CFG_BEIE_BIT];
        cfg_q[`CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] <= hwdata[`CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT];
        if (keyEnabled)
          cfg_q[`CFG_KEY_BIT] <= hwdata[`CFG_KEY_BIT];
      end
      // Set wins over a write-one clear in the same cycle
      if (arrayReq && arrayWrite && refuse)
        viol_q <= 1'b1;
      else if (wrPend_q && wrAddr_q == `STAT_ADDR &&
               hwdata[`STAT_VIOL_BIT])
        viol_q <= 1'b0;
      // Array gating
      cmdWriteStart <= arrayReq & arrayWrite & ~refuse &
                       ~cfg_q[`CFG_KEY_BIT];
      keyWrite     <= arrayReq & arrayWrite & ~arrayMassErase &
                      cfg_q[`CFG_KEY_BIT];
      arrayRefused <= arrayReq & arrayWrite & refuse &
                      ~cfg_q[`CFG_KEY_BIT];
      // Key mode reads return an invalid pattern rather than array data
      arrayRdData  <= cfg_q[`CFG_KEY_BIT] ? 16'hffff : arrayRdRaw;
      if (addrPhase && !hwrite) begin
        case (haddr)
          `CFG_ADDR:  hrdata <= {24'h000000, cfg_q & `CFG_MASK};
          `PROT_ADDR: hrdata <= {24'h000000, prot_q};
          `STAT_ADDR: hrdata <= {24'h000000, bufferEmptyFlag,
                                 commandCompleteFlag, viol_q, 5'h00};
          default:    hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign bufferEmptyIrq     = cfg_q[`CFG_BEIE_BIT] & bufferEmptyFlag;
  assign commandCompleteIrq = cfg_q[`CFG_COMMAND_COMPLETE_IRQ_ENABLE_BIT] &
                              commandCompleteFlag;
endmodule // flash_protection_config
`default_nettype wire

// [sim/flash_protection_config_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.vh"
module flash_protection_config_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // Flash side
  input wire logic [15:0] nvmLoadAddr,
  input wire logic        bufferEmptyFlag,
  input wire logic        commandCompleteFlag,
  input wire logic        arrayReq,
  input wire logic        arrayWrite,
  input wire logic        bufferEmptyIrq,
  input wire logic        commandCompleteIrq,
  input wire logic        cmdWriteStart,
  input wire logic        keyWrite,
  input wire logic        arrayRefused,
  input wire logic        protectionViolationFlag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_BE_IRQ: assert property (bufferEmptyIrq |-> bufferEmptyFlag)
    else $error("buffer empty irq without flag");
  AST_CC_IRQ: assert property
    (commandCompleteIrq |-> commandCompleteFlag)
    else $error("command complete irq without flag");
  AST_IRQ_RST: assert property ($fell(reset) |-> !bufferEmptyIrq)
    else $error("irq enable not cleared by reset");
  AST_START: assert property
    (cmdWriteStart |-> $past(arrayReq && arrayWrite))
    else $error("command start without array write");
  AST_KEY: assert property
    (keyWrite |-> !cmdWriteStart && $past(arrayWrite))
    else $error("key write with command start");
  AST_REFUSE: assert property
    (arrayRefused |-> protectionViolationFlag)
    else $error("refusal without violation flag");
  AST_LOAD_ADDR: assert property (nvmLoadAddr == `PROT_NVM_ADDR)
    else $error("protection byte address wrong");
  AST_CFG_READ: assert property
    ($past(hsel && hready && htrans[1] && !hwrite && haddr == `CFG_ADDR)
    |-> hrdata[31:8] == 0 && hrdata[4:0] == 0)
    else $error("config unused bits not zero");
  C_KEY: cover property (keyWrite);
  C_REFUSE: cover property (arrayRefused);
  C_START: cover property (cmdWriteStart);
endmodule // flash_protection_config_props
bind flash_protection_config flash_protection_config_props props (.clk_sys,
  .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .nvmLoadAddr,
  .bufferEmptyFlag, .commandCompleteFlag, .arrayReq, .arrayWrite,
  .bufferEmptyIrq, .commandCompleteIrq, .cmdWriteStart, .keyWrite,
  .arrayRefused, .protectionViolationFlag);
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_prot_map.vh"
module tb;
  logic        clk_sys = 0, reset = 1, hsel = 0, hwrite = 0, nvmLoadValid = 0;
  logic [7:0]  haddr = 0, nvmLoadData = 0;
  logic [1:0]  htrans = 0, backdoorKeyEnable = 0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 0, hrdata, rd;
  logic        bufferEmptyFlag = 0, commandCompleteFlag = 0, arrayReq = 0;
  logic        arrayWrite = 0, arrayMassErase = 0, hreadyout, hresp;
  logic [15:0] arrayAddr = 0, arrayRdRaw = 16'h1234, nvmLoadAddr, arrayRdData;
  logic        bufferEmptyIrq, commandCompleteIrq, cmdWriteStart, keyWrite;
  logic        arrayRefused, protectionViolationFlag;
  int          errCount = 0, nTests = 0, cyc = 0;
  flash_protection_config dut (.clk_sys, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .nvmLoadValid, .nvmLoadData, .nvmLoadAddr, .backdoorKeyEnable,
    .bufferEmptyFlag, .commandCompleteFlag, .arrayReq, .arrayWrite,
    .arrayMassErase, .arrayAddr, .arrayRdRaw, .bufferEmptyIrq,
    .commandCompleteIrq, .cmdWriteStart, .keyWrite, .arrayRefused,
    .arrayRdData, .protectionViolationFlag);
  always #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic giveVerdict;
    $display("checks %0d, mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic arr(input logic w, input logic m, input logic [15:0] a);
    @(posedge clk_sys);
    arrayReq <= 1'b1;
    arrayWrite <= w;
    arrayMassErase <= m;
    arrayAddr <= a;
    @(posedge clk_sys);
    arrayReq <= 1'b0;
    #1;
  endtask
  task automatic doReset(input logic [7:0] v);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    nvmLoadValid <= 1'b1;
    nvmLoadData <= v;
    @(posedge clk_sys);
    nvmLoadValid <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testCfg;
    bus(0, `CFG_ADDR, 0);
    chk(rd, 32'h0);
    // Gray order visits the enabled pattern last, so a stuck gate shows
    for (int k = 0; k < 4; k++) begin
      backdoorKeyEnable <= 2'(k ^ (k >> 1));
      bus(1, `CFG_ADDR, 32'hffff_ffff);
      bus(0, `CFG_ADDR, 0);
      chk(rd, (k == 3) ? 32'he0 : 32'hc0);
    end
    bufferEmptyFlag <= 1'b1;
    commandCompleteFlag <= 1'b1;
    arr(1, 0, 16'h8000);
    chk({keyWrite, cmdWriteStart, bufferEmptyIrq,
         commandCompleteIrq}, 4'hb);
    arr(0, 0, 16'h8000);
    chk(arrayRdData, 16'hffff);
    bus(1, `CFG_ADDR, 0);
    arr(1, 0, 16'h8000);
    chk({keyWrite, cmdWriteStart, bufferEmptyIrq,
         commandCompleteIrq}, 4'h4);
    arr(0, 0, 16'h8000);
    chk(arrayRdData, 16'h1234);
    bus(0, 8'h20, 0);
    chk(rd, 32'h0);
  endtask
  task automatic testProt;
    bus(0, `PROT_ADDR, 0);
    chk(rd, 32'hfe);
    arr(1, 1, 16'h0);
    chk({cmdWriteStart, arrayRefused}, 2'h2);
    bus(1, `PROT_ADDR, 32'hfd);
    bus(1, `PROT_ADDR, 32'hf9);
    // Resizing a live low range, to size 10 and then 00, must both be dropped
    bus(1, `PROT_ADDR, 32'hfa);
    bus(1, `PROT_ADDR, 32'hf8);
    bus(0, `PROT_ADDR, 0);
    chk(rd, 32'hf9);
    arr(1, 0, 16'h47ff);
    chk({arrayRefused, protectionViolationFlag}, 2'h3);
    bus(0, `STAT_ADDR, 0);
    chk(rd, 32'he0);
    bus(1, `STAT_ADDR, 32'h20);
    bus(0, `STAT_ADDR, 0);
    chk(rd, 32'hc0);
    arr(1, 0, 16'h4800);
    chk({cmdWriteStart, arrayRefused}, 2'h2);
    arr(1, 1, 16'h0);
    chk(arrayRefused, 1'b1);
  endtask
  task automatic testOpen;
    logic [15:0] adr [5] = '{16'hbfff, 16'hc000, 16'h5fff, 16'h6000, 16'h3fff};
    logic [4:0]  refExp = 5'b10011;
    bus(1, `PROT_ADDR, 32'hdb);
    bus(0, `PROT_ADDR, 0);
    chk(rd, 32'h5b);
    for (int i = 0; i < 5; i++) begin
      arr(1, 0, adr[i]);
      chk(arrayRefused, refExp[4 - i]);
    end
  endtask
  initial begin
    doReset(8'hfe);
    testCfg;
    testProt;
    doReset(8'h5b);
    testOpen;
    giveVerdict;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errCount++;
      giveVerdict;
    end
  end
endmodule // tb
`default_nettype wire
